/* File: rtl/irq_prio_pkg.sv */
// Constants, field positions and carrier types for the two level interrupt arbiter.
// Assumes a single clock that doubles as the oscillator of the core timing chain.
package irq_prio_pkg;

  localparam int NUM_SRC = 6;
  localparam int ADDR_W = 8;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_PRIORITY = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Priority select register fields
  localparam int PRIO_OFF_BIT = 7;
  localparam int LVL_THIRD_TIMER_BIT = 5;
  localparam int LVL_SERIAL_BIT = 4;
  localparam int LVL_SECOND_TIMER_BIT = 3;
  localparam int LVL_SECOND_EXT_BIT = 2;
  localparam int LVL_FIRST_TIMER_BIT = 1;
  localparam int LVL_FIRST_EXT_BIT = 0;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [7:0] PRIO_WR_MASK = 8'hbf;

  // Source enable register fields, same source order as priority
  localparam int GLOBAL_EN_BIT = 7;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_WR_MASK = 8'hbf;

  // Status register fields
  localparam int STAT_LO_BUSY_BIT = 0;
  localparam int STAT_HI_BUSY_BIT = 1;
  localparam int STAT_CALL_BIT = 2;
  localparam int STAT_SAMPLE_LSB = 8;
  localparam int STAT_MSTATE_LSB = 16;

  // Machine cycle timing in oscillator periods
  localparam int OSC_PER_STATE = 2;
  localparam int STATES_PER_CYCLE = 6;
  localparam logic [2:0] SAMPLE_STATE = 3'h5;
  localparam logic [2:0] POLL_STATE = 3'h1;
  localparam int CYCLE_OSC = OSC_PER_STATE * STATES_PER_CYCLE;

  // Vector layout
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Hardware call request handed to the core
  typedef struct packed {
    logic [15:0] addr;
    logic [2:0] src;
    logic high;
  } call_req_type;

  typedef enum logic [1:0] {
    CALL_IDLE = 2'b01,
    CALL_ASK = 2'b10
  } call_state_type;

endpackage : irq_prio_pkg

/* File: rtl/irq_prio_arbiter.sv */
// Two level interrupt priority arbiter with AXI4-Lite register access.
// Assumes source flags and core handshakes come from logic on aclk.
//
// What this block does
// - Every source owns one priority bit; a one puts it at high level.
// - During low level service only a high level request may preempt.
// - During high level service no further request is accepted.
// - Simultaneous requests of both levels: the high level one wins.
// - Within one level a fixed polling order picks the winner.
// - Priority bit seven set stops level arbitration; enables alone govern.
// - Priority bit five sets the third timer level.
// - Priority bit four sets the serial port level.
// - Priority bit three sets the second timer level.
// - Priority bit two sets the second external interrupt level.
// - Priority bit one sets the first timer level.
// - Priority bit zero sets the first external interrupt level.
// - All flags are captured during state five of every machine cycle.
// - Captured samples are polled in the following machine cycle.
// - An enabled unblocked flag makes the core perform a long vector call.
// - A request is blocked while equal or higher level service runs.
// - The call pushes the program counter then loads the routine address.
// - Only the program counter is saved by hardware, nothing else.
// - Return from service clears the in-progress flag of its level.
// - Global enable bit low stops every acknowledge.
// - Enable bits zero to five enable each source, same order as priority.
// - A machine cycle is six states of two oscillator periods.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

module irq_prio_arbiter
  import irq_prio_pkg::*;
(
  input wire logic aclk, // Oscillator rate clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [NUM_SRC-1:0] src_flag, // Source flags, poll order in bit order
  output logic call_valid, // Hardware call requested of the core
  output call_req_type call_req, // Vector, source and level of the call
  input wire logic call_ack, // Core has pushed the program counter and jumped
  input wire logic return_from_service, // Core executed the return instruction
  output logic [2:0] machine_state // Current state number, 1 to 6
);

  // Lowest set bit gives the polling winner
  function automatic logic [2:0] first_set(input logic [NUM_SRC-1:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (m[i]) idx = 3'(i);
    end
    return idx;
  endfunction : first_set

  // Fixed vector of a source
  function automatic logic [15:0] vector_of(input logic [2:0] src);
    return VEC_BASE + 16'(VEC_STEP * 16'(src));
  endfunction : vector_of

  logic [7:0] priority_select_reg_r;
  logic [7:0] source_enable_reg_r;
  logic [NUM_SRC-1:0] sample_r;
  logic osc_r;
  logic [2:0] state_r;
  logic in_prog_hi_r;
  logic in_prog_lo_r;
  call_state_type call_st_r;
  logic awready_r;
  logic arready_r;
  logic bvalid_r;
  logic rvalid_r;
  logic [1:0] bresp_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  call_req_type call_r;

  // Machine cycle timing: two oscillator periods per state, six states
  wire state_last_osc = osc_r == 1'(OSC_PER_STATE - 1);
  wire sample_en = state_last_osc && state_r == SAMPLE_STATE;
  wire poll_en = !osc_r && state_r == POLL_STATE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_r <= 1'b0;
      state_r <= 3'h1;
    end else begin
      osc_r <= !state_last_osc;
      if (state_last_osc) state_r <= (state_r == 3'(STATES_PER_CYCLE)) ? 3'h1 : state_r + 3'h1;
    end
  end

  // Flag capture late in state five
  always_ff @(posedge aclk) begin
    if (!aresetn) sample_r <= '0;
    else if (sample_en) sample_r <= src_flag;
  end

  // Enable gating and level split
  wire global_enable_bit = source_enable_reg_r[GLOBAL_EN_BIT];
  wire priority_circuit_off = priority_select_reg_r[PRIO_OFF_BIT];
  wire [NUM_SRC-1:0] level_bits = {
    priority_select_reg_r[LVL_THIRD_TIMER_BIT],
    priority_select_reg_r[LVL_SERIAL_BIT],
    priority_select_reg_r[LVL_SECOND_TIMER_BIT],
    priority_select_reg_r[LVL_SECOND_EXT_BIT],
    priority_select_reg_r[LVL_FIRST_TIMER_BIT],
    priority_select_reg_r[LVL_FIRST_EXT_BIT]
  };
  wire [NUM_SRC-1:0] armed = sample_r & source_enable_reg_r[NUM_SRC-1:0];
  wire [NUM_SRC-1:0] eligible = global_enable_bit ? armed : '0;
  wire [NUM_SRC-1:0] hi_req = priority_circuit_off ? '0 : eligible & level_bits;
  wire [NUM_SRC-1:0] lo_req = priority_circuit_off ? eligible : eligible & ~level_bits;

  // Blocking by service already in progress
  wire allow_hi = !in_prog_hi_r;
  wire allow_lo = !in_prog_hi_r && !in_prog_lo_r;
  wire pick_high = |hi_req && allow_hi;
  wire pick_low = !pick_high && |lo_req && allow_lo;
  wire [NUM_SRC-1:0] pick_mask = pick_high ? hi_req : lo_req;
  wire [2:0] pick_idx = first_set(pick_mask);
  wire start = poll_en && call_st_r == CALL_IDLE && (pick_high || pick_low);
  wire accepted = call_st_r == CALL_ASK && call_ack;

  // Call request toward the core; core pushes only the program counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      call_st_r <= CALL_IDLE;
      call_r <= '0;
    end else begin
      case (call_st_r)
        CALL_IDLE: begin
          if (start) begin
            call_st_r <= CALL_ASK;
            call_r <= '{addr: vector_of(pick_idx), src: pick_idx, high: pick_high};
          end
        end
        CALL_ASK: begin
          if (call_ack) call_st_r <= CALL_IDLE;
        end
        default: call_st_r <= CALL_IDLE;
      endcase
    end
  end

  // In-progress flags; an acceptance wins over a return in the same cycle
  wire clr_hi = return_from_service && in_prog_hi_r;
  wire clr_lo = return_from_service && !in_prog_hi_r && in_prog_lo_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_prog_hi_r <= 1'b0;
      in_prog_lo_r <= 1'b0;
    end else begin
      in_prog_hi_r <= (accepted && call_r.high) || (in_prog_hi_r && !clr_hi);
      in_prog_lo_r <= (accepted && !call_r.high) || (in_prog_lo_r && !clr_lo);
    end
  end

  // AXI4-Lite write path: address and data taken together
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
  wire wr_take = awready_r && s_axi_awvalid && s_axi_wvalid;
  wire wr_prio = s_axi_awaddr == OFS_PRIORITY;
  wire wr_enab = s_axi_awaddr == OFS_ENABLE;
  wire wr_known = wr_prio || wr_enab || s_axi_awaddr == OFS_STATUS;
  wire [7:0] wbyte = s_axi_wdata[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      awready_r <= wr_go;
      if (wr_take) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) bvalid_r <= 1'b0;
    end
  end

  // Software registers; reserved bit six stays zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      priority_select_reg_r <= PRIO_RESET;
      source_enable_reg_r <= ENABLE_RESET;
    end else if (wr_take && s_axi_wstrb[0]) begin
      if (wr_prio) priority_select_reg_r <= wbyte & PRIO_WR_MASK;
      if (wr_enab) source_enable_reg_r <= wbyte & ENABLE_WR_MASK;
    end
  end

  // AXI4-Lite read path
  wire rd_go = s_axi_arvalid && !arready_r && !rvalid_r;
  wire rd_take = arready_r && s_axi_arvalid;
  wire [31:0] status_word = {13'h0, state_r, 2'h0, sample_r, 5'h0,
                             call_st_r == CALL_ASK, in_prog_hi_r, in_prog_lo_r};
  wire rd_prio = s_axi_araddr == OFS_PRIORITY;
  wire rd_enab = s_axi_araddr == OFS_ENABLE;
  wire rd_stat = s_axi_araddr == OFS_STATUS;
  wire [31:0] rd_word = rd_prio ? {24'h0, priority_select_reg_r} :
                        rd_enab ? {24'h0, source_enable_reg_r} :
                        rd_stat ? status_word : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0;
    end else begin
      arready_r <= rd_go;
      if (rd_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= (rd_prio || rd_enab || rd_stat) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) rvalid_r <= 1'b0;
    end
  end

  // Outputs straight from flip-flops, call_valid decoded from call_st_r
  assign s_axi_awready = awready_r;
  assign s_axi_wready = awready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign call_valid = call_st_r == CALL_ASK;
  assign call_req = call_r;
  assign machine_state = state_r;

  // Clocks since the last capture; feeds the machine cycle length check
  logic [3:0] gap_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) gap_r <= 4'h0;
    else if (sample_en) gap_r <= 4'h0;
    else gap_r <= gap_r + 4'h1;
  end

  // Checks on the arbiter
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence next_capture_s;
    ##12 (sample_en && gap_r == 4'(CYCLE_OSC - 1));
  endsequence

  sequence call_taken_s;
    call_valid && call_ack;
  endsequence

  cycle_length_a: assert property (
    sample_en |-> next_capture_s)
    else $error("machine cycle is not twelve clocks");

  poll_follows_a: assert property (
    sample_en |-> !poll_en ##3 poll_en)
    else $error("poll not three clocks after capture");

  capture_state_a: assert property (
    sample_en |=> sample_r == $past(src_flag) && machine_state == 3'h6)
    else $error("flags not captured at the end of state five");

  high_blocks_all_a: assert property (
    in_prog_hi_r |-> !start)
    else $error("request accepted during high level service");

  low_preempt_a: assert property (
    start && in_prog_lo_r |=> call_valid && call_req.high)
    else $error("low level request preempted low level service");

  high_first_a: assert property (
    start && |hi_req |=> call_req.high)
    else $error("low level chosen over high level");

  poll_order_a: assert property (
    start |-> pick_mask[pick_idx] && (pick_mask & ((6'h01 << pick_idx) - 6'h01)) == 6'h00)
    else $error("polling order not respected");

  vector_addr_a: assert property (
    start |=> call_req.addr == 16'(16'h0003 + 16'h0008 * 16'(call_req.src)))
    else $error("wrong vector address");

  global_off_a: assert property (
    !source_enable_reg_r[7] |-> !start)
    else $error("call raised with global enable low");

  circuit_off_a: assert property (
    start && priority_select_reg_r[7] |=> !call_req.high)
    else $error("level arbitration active while stopped");

  call_hold_a: assert property (
    call_valid && !call_ack |=> call_valid && $stable(call_req))
    else $error("call request dropped before acknowledge");

  ack_marks_a: assert property (
    call_taken_s ##0 call_req.high |=> in_prog_hi_r && !call_valid)
    else $error("high level in-progress not set on acknowledge");

  return_from_service_clears_a: assert property (
    return_from_service && in_prog_hi_r && !call_ack |=> !in_prog_hi_r)
    else $error("return did not clear high level in-progress");

  lo_waits_a: assert property (
    in_prog_lo_r && hi_req == 6'h00 |-> !start)
    else $error("low level request started during low level service");

  return_from_service_low_a: assert property (
    return_from_service && in_prog_lo_r && !in_prog_hi_r && !call_ack |=> !in_prog_lo_r)
    else $error("return did not clear low level in-progress");

  enable_gate_a: assert property (
    start |-> source_enable_reg_r[pick_idx] && sample_r[pick_idx])
    else $error("call started for a disabled or unsampled source");

  level_pick_a: assert property (
    start |-> pick_high == (priority_select_reg_r[pick_idx] && !priority_circuit_off))
    else $error("call level does not match the source priority bit");

  ack_low_a: assert property (
    call_taken_s ##0 !call_req.high |=> in_prog_lo_r && !call_valid)
    else $error("low level in-progress not set on acknowledge");

endmodule : irq_prio_arbiter

/* File: test/core_model.sv */
// Behavioural core that takes hardware calls and executes returns.
// Assumes call_valid stands until call_ack, and one bench request per return.
`timescale 1ns/1ps

module core_model
  import irq_prio_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic call_valid, // Call wanted
  input wire call_req_type call_req, // Vector of the call
  input wire logic [3:0] ack_delay, // Stall cycles before a call is taken
  input wire logic ret_go, // Bench asks for a return
  output logic call_ack, // Call taken
  output logic return_from_service // Return executed
);
  logic [3:0] wait_r;
  logic [15:0] pc_r;

  // Stall, then load the program counter with the vector
  wire ack_now = call_valid && !call_ack && wait_r == ack_delay;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_r <= 4'h0;
      pc_r <= 16'h0000;
      call_ack <= 1'b0;
      return_from_service <= 1'b0;
    end else begin
      call_ack <= ack_now;
      return_from_service <= ret_go;
      if (ack_now) begin
        wait_r <= 4'h0;
        pc_r <= call_req.addr;
      end else if (call_valid && !call_ack) wait_r <= wait_r + 4'h1;
    end
  end
endmodule : core_model

/* File: test/two_level_interrupt_priority_tb_top.sv */
// Bench for the two level interrupt arbiter: registers, arbitration, blocking.
// Assumes the core model answers calls; all inputs change just after aclk rises.
`timescale 1ns/1ps

module two_level_interrupt_priority_tb_top
  import irq_prio_pkg::*;
;
  typedef struct packed {
    logic [7:0] prio;
    logic [7:0] en;
    logic [5:0] flags;
    logic [3:0] dly;
    logic [2:0] src;
    logic high;
  } row_type;

  logic aclk, aresetn, ret_go, call_valid, call_ack, return_from_service;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, ack_delay;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] src_flag;
  logic [2:0] machine_state;
  call_req_type call_req;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  row_type rows [10] = '{
    '{8'h00, 8'hbf, 6'h3f, 4'h0, 3'h0, 1'b0},
    '{8'h20, 8'hbf, 6'h3f, 4'h5, 3'h5, 1'b1},
    '{8'h10, 8'hbf, 6'h3f, 4'h0, 3'h4, 1'b1},
    '{8'h08, 8'hbf, 6'h3f, 4'h2, 3'h3, 1'b1},
    '{8'h04, 8'hbf, 6'h3f, 4'h0, 3'h2, 1'b1},
    '{8'h02, 8'hbf, 6'h3f, 4'h0, 3'h1, 1'b1},
    '{8'h01, 8'hbf, 6'h3f, 4'h0, 3'h0, 1'b1},
    '{8'h00, 8'h9e, 6'h3f, 4'h0, 3'h1, 1'b0},
    '{8'ha0, 8'hbf, 6'h3f, 4'h0, 3'h0, 1'b0},
    '{8'h00, 8'hbf, 6'h30, 4'h1, 3'h4, 1'b0}};

  irq_prio_arbiter DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .src_flag, .call_valid, .call_req, .call_ack,
    .return_from_service, .machine_state);
  core_model core (.aclk, .aresetn, .call_valid, .call_req, .ack_delay, .ret_go, .call_ack,
    .return_from_service);

  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Bus master: both write channels offered together, bready held until bvalid
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    chk("wready", 32'h1, {31'h0, s_axi_wready});
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, rsp}, {30'h0, s_axi_bresp});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp,
    input logic [1:0] rsp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", exp, s_axi_rdata & msk);
    chk("rresp", {30'h0, rsp}, {30'h0, s_axi_rresp});
  endtask : axi_read

  // Watch for a call within forty clocks and compare what it carries
  task automatic expect_call(input logic got, input logic [2:0] src, input logic high);
    int i;
    i = 0;
    while (call_valid !== 1'b1 && i < 40) begin
      @(posedge aclk);
      i++;
    end
    chk("call_valid", {31'h0, got}, {31'h0, call_valid});
    if (got) begin
      chk("call_src", {29'h0, src}, {29'h0, call_req.src});
      chk("call_vec", {16'h0, VEC_BASE + VEC_STEP * {13'h0, src}}, {16'h0, call_req.addr});
      chk("call_high", {31'h0, high}, {31'h0, call_req.high});
      while (call_valid === 1'b1) @(posedge aclk);
      chk("core_pc", {16'h0, VEC_BASE + VEC_STEP * {13'h0, src}}, {16'h0, core.pc_r});
    end
  endtask : expect_call

  task automatic do_return;
    @(posedge aclk);
    ret_go <= 1'b1;
    @(posedge aclk);
    ret_go <= 1'b0;
  endtask : do_return

  task automatic wait_state(input logic [2:0] s);
    do @(posedge aclk); while (machine_state !== s);
  endtask : wait_state

  // Main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, src_flag, ret_go} = '0;
    s_axi_wstrb = 4'h1;
    ack_delay = 4'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(OFS_PRIORITY, 32'hff, {24'h0, PRIO_RESET}, RESP_OKAY);
    axi_read(OFS_STATUS, 32'h3, 32'h0, RESP_OKAY);
    axi_read(8'h0c, 32'hffffffff, 32'h0, RESP_SLVERR);
    axi_write(8'h10, 32'hff, RESP_SLVERR);
    axi_write(OFS_PRIORITY, 32'hff, RESP_OKAY);
    axi_read(OFS_PRIORITY, 32'hffffffff, 32'hbf, RESP_OKAY);
    wait_state(3'h6);
    wait_state(3'h1);
    for (int i = 0; i < CYCLE_OSC; i++) begin
      chk("machine_state", 32'(i / 2 + 1), {29'h0, machine_state});
      @(posedge aclk);
    end
    foreach (rows[i]) begin
      axi_write(OFS_PRIORITY, {24'h0, rows[i].prio}, RESP_OKAY);
      axi_write(OFS_ENABLE, {24'h0, rows[i].en}, RESP_OKAY);
      ack_delay <= rows[i].dly;
      src_flag <= rows[i].flags;
      expect_call(1'b1, rows[i].src, rows[i].high);
      src_flag <= 6'h00;
      axi_read(OFS_STATUS, 32'h3, rows[i].high ? 32'h2 : 32'h1, RESP_OKAY);
      repeat (CYCLE_OSC) @(posedge aclk);
      do_return();
      axi_read(OFS_STATUS, 32'h3, 32'h0, RESP_OKAY);
    end
    // Global enable off: nothing is acknowledged
    axi_write(OFS_PRIORITY, 32'h20, RESP_OKAY);
    axi_write(OFS_ENABLE, 32'h3f, RESP_OKAY);
    src_flag <= 6'h3f;
    expect_call(1'b0, 3'h0, 1'b0);
    src_flag <= 6'h01;
    repeat (CYCLE_OSC) @(posedge aclk);
    axi_write(OFS_ENABLE, 32'hbf, RESP_OKAY);
    expect_call(1'b1, 3'h0, 1'b0);
    // Low service runs: another low waits, a high one preempts
    src_flag <= 6'h11;
    expect_call(1'b0, 3'h0, 1'b0);
    src_flag <= 6'h31;
    expect_call(1'b1, 3'h5, 1'b1);
    axi_read(OFS_STATUS, 32'h3, 32'h3, RESP_OKAY);
    expect_call(1'b0, 3'h0, 1'b0);
    src_flag <= 6'h11;
    repeat (CYCLE_OSC) @(posedge aclk);
    do_return();
    axi_read(OFS_STATUS, 32'h3, 32'h1, RESP_OKAY);
    expect_call(1'b0, 3'h0, 1'b0);
    src_flag <= 6'h00;
    repeat (CYCLE_OSC) @(posedge aclk);
    do_return();
    axi_read(OFS_STATUS, 32'h3, 32'h0, RESP_OKAY);
    // Flag dropped before the end of state five is never captured
    wait_state(3'h1);
    src_flag <= 6'h01;
    wait_state(3'h5);
    src_flag <= 6'h00;
    expect_call(1'b0, 3'h0, 1'b0);
    wait_state(3'h5);
    src_flag <= 6'h01;
    wait_state(3'h6);
    src_flag <= 6'h00;
    chk("early_call", 32'h0, {31'h0, call_valid});
    expect_call(1'b1, 3'h0, 1'b0);
    // Second reset in mid-service clears levels and service state
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(OFS_PRIORITY, 32'hff, 32'h0, RESP_OKAY);
    axi_read(OFS_STATUS, 32'h3, 32'h0, RESP_OKAY);
    complete_run();
  end
endmodule : two_level_interrupt_priority_tb_top
